// [rtl/pfm_port_mux.sv]
// pin-function multiplexer for the eight-port microcontroller I/O
// assumes a classic Wishbone master on sys_clk and pins resolved outside
`timescale 1ns/1ps
module pfm_port_mux (
   input  wire logic                 sys_clk,
   input  wire logic                 srst,
   input  wire pfm_pkg::pfm_wb_req_t wb_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic [1:0]           mode_pin,
   input  wire pfm_pkg::pfm_func_t   func_i,
   input  wire pfm_pkg::pfm_port_arr_t pin_in,
   output pfm_pkg::pfm_port_arr_t    pin_out,
   output pfm_pkg::pfm_port_arr_t    pin_oe,
   output pfm_pkg::pfm_port_arr_t    pin_level,
   output logic [2:0]                host_reg_select
);
   import pfm_pkg::*;

   pfm_state_t q;
   pfm_state_t d;

   // mixes a function drive into a GPIO pin group
   function automatic pfm_pin_t merge(
      input logic [7:0] f,
      input logic [7:0] v,
      input logic [7:0] dir,
      input logic [7:0] lat
   );
      pfm_pin_t r;
      r.out = (f & v) | (~f & lat);
      r.oe  = f | dir;
      return r;
   endfunction

   // what software sees at a data location
   function automatic logic [7:0] port_read(
      input logic [7:0] dir,
      input logic [7:0] lat,
      input logic [7:0] pin
   );
      return (dir & lat) | (~dir & pin);
   endfunction

   logic       host_act;
   logic       m_exp1;
   logic       m_exp2;
   logic [2:0] region;
   logic [2:0] idx;
   pfm_pin_t   g;
   logic [7:0] f6;
   logic [7:0] v6;

   assign region = wb_i.adr[7:5];
   assign idx    = wb_i.adr[4:2];
   assign m_exp1 = (q.mode == PFM_MODE_EXP1);
   assign m_exp2 = (q.mode == PFM_MODE_EXP2);
   // host port only acts in single-chip mode; a strap of 0 counts as single-chip too
   assign host_act = !m_exp1 && !m_exp2 && q.host_en;

   // whole next state, one block; outputs are all taken from q
   always_comb begin
      d = q;
      g = '0;
      f6 = '0;
      v6 = '0;
      d.mode_s1 = mode_pin;
      d.mode_s2 = q.mode_s1;
      d.pin_s1  = pin_in;
      d.pin_s2  = q.pin_s1;

      // strap caught once the synchroniser has filled after release
      if (!q.mode_ok) begin
         if (q.mode_wait == PFM_SYNC_LAT) begin
            d.mode_ok = 1'b1;
            d.mode    = q.mode_s2;
            d.dir[PFM_P1] = (q.mode_s2 == PFM_MODE_EXP1) ? PFM_ALL_OUT : PFM_ALL_IN;
         end else begin
            d.mode_wait = q.mode_wait + 2'h1;
         end
      end

      // bus slave: one wait state, ack for one cycle, unmapped reads zero
      d.ack = 1'b0;
      if (wb_i.cyc && wb_i.stb && !q.ack) begin
         d.ack  = 1'b1;
         d.rdat = '0;
         case (region)
            PFM_REG_DIR: begin
               d.rdat[7:0] = q.dir[idx];
               if (wb_i.we && wb_i.sel[0]) begin
                  d.dir[idx] = wb_i.dat[7:0] & PFM_DIR_MASK[idx];
               end
            end
            PFM_REG_LATCH: begin
               d.rdat[7:0] = port_read(q.dir[idx], q.latch[idx], q.pin_s2[idx]) & PFM_PORT_MASK[idx];
               if (wb_i.we && wb_i.sel[0]) begin
                  d.latch[idx] = wb_i.dat[7:0] & PFM_PORT_MASK[idx];
               end
            end
            PFM_REG_MISC: begin
               case (idx)
                  PFM_IDX_PULSE1, PFM_IDX_PULSE2: begin
                     d.rdat[7:0] = q.pulse_en[idx[0]];
                     if (wb_i.we && wb_i.sel[0]) begin
                        d.pulse_en[idx[0]] = wb_i.dat[7:0];
                     end
                  end
                  PFM_IDX_CTRL: begin
                     d.rdat[PFM_CTRL_HOST_BIT] = q.host_en;
                     d.rdat[PFM_CTRL_MODE_LSB +: 2] = q.mode;
                     if (wb_i.we && wb_i.sel[0]) begin
                        d.host_en = wb_i.dat[PFM_CTRL_HOST_BIT];
                     end
                  end
                  default: begin
                     d.rdat = '0;
                  end
               endcase
            end
            default: begin
               d.rdat = '0;
            end
         endcase
      end

      // plain GPIO for every pin, then function overrides
      for (int k = 0; k < PFM_NPORT; k++) begin
         d.pin_out[k] = q.latch[k];
         d.pin_oe[k]  = q.dir[k];
      end

      // ports 1 and 2: address, pulse or GPIO
      for (int k = 0; k < 2; k++) begin
         if (m_exp1) begin
            d.pin_oe[k]  = PFM_ALL_OUT;
            d.pin_out[k] = func_i.addr[k*8 +: 8];
         end else begin
            d.pin_oe[k]  = q.dir[k];
            d.pin_out[k] = (q.pulse_en[k] & func_i.pulse[k*8 +: 8])
                         | (~q.pulse_en[k] & (m_exp2 ? func_i.addr[k*8 +: 8] : q.latch[k]));
         end
      end

      // port 3: external data bus, shared RAM bus or GPIO
      if (m_exp1 || m_exp2) begin
         d.pin_out[PFM_P3] = func_i.xbus_out;
         d.pin_oe[PFM_P3]  = {8{func_i.xbus_oe}};
      end else if (host_act) begin
         d.pin_out[PFM_P3] = func_i.host_out;
         d.pin_oe[PFM_P3]  = {8{func_i.host_oe}};
      end

      // port 4: alternate shared RAM bus wins over timers
      if (host_act) begin
         d.pin_out[PFM_P4] = func_i.alt_out;
         d.pin_oe[PFM_P4]  = {8{func_i.alt_oe}};
      end else begin
         g = merge(func_i.p4_oe, func_i.p4_out, q.dir[PFM_P4], q.latch[PFM_P4]);
         d.pin_out[PFM_P4] = g.out;
         d.pin_oe[PFM_P4]  = g.oe;
      end

      // port 5: serial 0 in every mode
      g = merge({5'h00, func_i.s0_oe}, {5'h00, func_i.s0_out}, q.dir[PFM_P5], q.latch[PFM_P5]);
      d.pin_out[PFM_P5] = g.out;
      d.pin_oe[PFM_P5]  = g.oe;

      // port 6: timer8 drives only join when the host port is on
      f6 = func_i.frt_oe | (host_act ? func_i.t8_oe : PFM_ALL_IN);
      v6 = host_act ? ((func_i.t8_oe & func_i.t8_out) | (~func_i.t8_oe & func_i.frt_out)) : func_i.frt_out;
      g = merge(f6, v6, q.dir[PFM_P6], q.latch[PFM_P6]);
      d.pin_out[PFM_P6] = g.out;
      d.pin_oe[PFM_P6]  = g.oe;

      // port 8: with the host port on, strobes and selects are inputs and the request pin drives; else serial 1 or GPIO
      if (host_act) begin
         d.pin_oe[PFM_P8]  = (q.dir[PFM_P8] & ~PFM_P8_HOSTIN) | PFM_P8_WRQ;
         d.pin_out[PFM_P8] = (q.latch[PFM_P8] & ~PFM_P8_WRQ) | ({8{func_i.write_request_out}} & PFM_P8_WRQ);
      end else begin
         g = merge(func_i.s1_oe, func_i.s1_out, q.dir[PFM_P8], q.latch[PFM_P8]);
         d.pin_out[PFM_P8] = g.out;
         d.pin_oe[PFM_P8]  = g.oe;
      end

      // unimplemented pins and port 7 never drive
      for (int k = 0; k < PFM_NPORT; k++) begin
         d.pin_oe[k]  = d.pin_oe[k] & PFM_DIR_MASK[k];
         d.pin_out[k] = d.pin_out[k] & PFM_PORT_MASK[k];
      end

      d.rs = host_act ? q.pin_s2[PFM_P8][2:0] : 3'h0;
   end

   // single state register; reset parks every pin as input
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         q      <= '0;
         q.mode <= PFM_MODE_SINGLE;
      end else begin
         q <= d;
      end
   end

   assign wb_dat_o        = q.rdat;
   assign wb_ack_o        = q.ack;
   assign pin_out         = q.pin_out;
   assign pin_oe          = q.pin_oe;
   assign pin_level       = q.pin_s2;
   assign host_reg_select = q.rs;

   // checks; drives lag their cause by one clock
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_mode1_addr: assert property (q.mode_ok && m_exp1 |=>
      pin_oe[PFM_P1] == PFM_ALL_OUT && pin_out[PFM_P2] == $past(func_i.addr[15:8]))
      else $error("mode 1 address not on ports 1 and 2");
   chk_p1_input: assert property (q.mode_ok && !m_exp1 |=>
      (pin_oe[PFM_P1] & ~$past(q.dir[PFM_P1])) == PFM_ALL_IN)
      else $error("port 1 drives a pin with direction 0");
   chk_mode2_addr: assert property (q.mode_ok && m_exp2 && q.pulse_en[0] == PFM_ALL_IN |=>
      pin_out[PFM_P1] == $past(func_i.addr[7:0]))
      else $error("mode 2 address bits missing");
   chk_mode3_gpio: assert property (q.mode == PFM_MODE_SINGLE && q.pulse_en[1] == PFM_ALL_IN |=>
      pin_out[PFM_P2] == $past(q.latch[PFM_P2]))
      else $error("mode 3 port 2 not driving latch");
   chk_pulse_out: assert property (!m_exp1 && q.pulse_en[0] == PFM_ALL_OUT |=>
      pin_out[PFM_P1] == $past(func_i.pulse[7:0]))
      else $error("pulse output not on port 1");
   chk_data_bus: assert property ((m_exp1 || m_exp2) |=>
      pin_oe[PFM_P3] == {8{$past(func_i.xbus_oe)}})
      else $error("port 3 not following external bus");
   chk_port7_in: assert property (pin_oe[PFM_P7] == PFM_ALL_IN)
      else $error("port 7 drove a pin");
   chk_host_sel: assert property (host_act |=>
      (pin_oe[PFM_P8] & PFM_P8_HOSTIN) == PFM_ALL_IN && pin_oe[PFM_P8][3])
      else $error("host port 8 pin directions wrong");
   chk_p1_reset: assert property ($rose(q.mode_ok) |->
      q.dir[PFM_P1] == ((q.mode == PFM_MODE_EXP1) ? PFM_ALL_OUT : PFM_ALL_IN))
      else $error("port 1 direction reset value wrong");

   // host port, serial, timer, bus and port 7 checks; pins follow one clock behind
   chk_ack_next: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   chk_p7_dir: assert property (q.dir[PFM_P7] == PFM_ALL_IN)
      else $error("port 7 direction bits set");
   chk_host_data: assert property (host_act |=>
      pin_out[PFM_P3] == $past(func_i.host_out) && pin_oe[PFM_P3] == {8{$past(func_i.host_oe)}})
      else $error("port 3 not on shared ram bus");
   chk_host_off: assert property (q.mode_ok && !m_exp1 && !m_exp2 && !q.host_en |=>
      pin_oe[PFM_P3] == $past(q.dir[PFM_P3]))
      else $error("port 3 not general I/O with host port off");
   chk_alt_bus: assert property (host_act |=>
      pin_out[PFM_P4] == $past(func_i.alt_out) && pin_oe[PFM_P4] == {8{$past(func_i.alt_oe)}})
      else $error("port 4 not on alternate shared ram bus");
   chk_serial0: assert property (q.mode_ok |=>
      (pin_oe[PFM_P5] & ~PFM_PORT_MASK[PFM_P5]) == PFM_ALL_IN
      && (pin_out[PFM_P5][2:0] & $past(func_i.s0_oe)) == ($past(func_i.s0_out) & $past(func_i.s0_oe)))
      else $error("port 5 serial drive wrong");
   chk_t8_join: assert property (host_act |=>
      (pin_oe[PFM_P6] & $past(func_i.t8_oe)) == $past(func_i.t8_oe))
      else $error("timer8 drive missing on port 6");
   chk_p8_wrq: assert property (host_act |=>
      (pin_out[PFM_P8] & PFM_P8_WRQ) == ({8{$past(func_i.write_request_out)}} & PFM_P8_WRQ))
      else $error("write request level not on port 8");
   chk_p8_gpio: assert property (q.mode_ok && !host_act |=>
      (pin_oe[PFM_P8] & ~$past(q.dir[PFM_P8] | func_i.s1_oe)) == PFM_ALL_IN)
      else $error("port 8 drives a pin nobody asked for");
   chk_read_mix: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o && !wb_i.we
      && region == PFM_REG_LATCH && idx == PFM_P7 |=> wb_dat_o[7:0] == $past(q.pin_s2[PFM_P7]))
      else $error("port 7 read not showing pin levels");

   // scenarios worth seeing at least once
   cov_host_mode: cover property (host_act ##1 pin_oe[PFM_P8][3]);
   cov_mode1: cover property ($rose(q.mode_ok) && m_exp1);
   cov_mode2: cover property ($rose(q.mode_ok) && m_exp2);
   cov_pulse: cover property (!m_exp1 && q.pulse_en[0] == PFM_ALL_OUT);
   cov_read: cover property (wb_ack_o && wb_i.cyc && !wb_i.we);
endmodule

// [common/pfm_pkg.sv]
// port_pin_function_mux shared constants, register map and carrier types
// assumes one system clock; pins resolved outside from level/oe pairs
package pfm_pkg;

   localparam int PFM_NPORT = 8;             // index 0 is port 1 ... index 7 is port 8
   localparam int PFM_P1    = 0;
   localparam int PFM_P2    = 1;
   localparam int PFM_P3    = 2;
   localparam int PFM_P4    = 3;
   localparam int PFM_P5    = 4;
   localparam int PFM_P6    = 5;
   localparam int PFM_P7    = 6;
   localparam int PFM_P8    = 7;

   // operating modes as strapped on the mode pins
   localparam logic [1:0] PFM_MODE_EXP1   = 2'h1;
   localparam logic [1:0] PFM_MODE_EXP2   = 2'h2;
   localparam logic [1:0] PFM_MODE_SINGLE = 2'h3;
   localparam logic [1:0] PFM_SYNC_LAT    = 2'h2;

   // implemented pins per port, and pins that may ever drive
   localparam logic [7:0][7:0] PFM_PORT_MASK = {8'h7F, 8'hFF, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
   localparam logic [7:0][7:0] PFM_DIR_MASK  = {8'h7F, 8'h00, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   localparam logic [7:0] PFM_ALL_IN   = 8'h00;
   localparam logic [7:0] PFM_ALL_OUT  = 8'hFF;
   localparam logic [7:0] PFM_P8_HOSTIN = 8'h57;   // strobes and register selects
   localparam logic [7:0] PFM_P8_WRQ    = 8'h08;   // write request / ready pin

   // register map: byte address = {region, index, 2'b00}
   localparam logic [2:0] PFM_REG_DIR   = 3'h0;    // 0x00..0x1C direction
   localparam logic [2:0] PFM_REG_LATCH = 3'h1;    // 0x20..0x3C data location
   localparam logic [2:0] PFM_REG_MISC  = 3'h2;
   localparam logic [2:0] PFM_IDX_PULSE1 = 3'h0;   // 0x40
   localparam logic [2:0] PFM_IDX_PULSE2 = 3'h1;   // 0x44
   localparam logic [2:0] PFM_IDX_CTRL   = 3'h2;   // 0x48
   localparam int PFM_CTRL_HOST_BIT = 0;
   localparam int PFM_CTRL_MODE_LSB = 1;

   typedef logic [7:0][7:0] pfm_port_arr_t;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pfm_pin_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } pfm_wb_req_t;

   // drive requests from the on-chip functions sharing the pins
   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] pulse;
      logic [7:0]  xbus_out;
      logic        xbus_oe;
      logic [7:0]  host_out;
      logic        host_oe;
      logic [7:0]  alt_out;
      logic        alt_oe;
      logic [7:0]  p4_out;
      logic [7:0]  p4_oe;
      logic [2:0]  s0_out;
      logic [2:0]  s0_oe;
      logic [7:0]  frt_out;
      logic [7:0]  frt_oe;
      logic [7:0]  t8_out;
      logic [7:0]  t8_oe;
      logic [7:0]  s1_out;
      logic [7:0]  s1_oe;
      logic        write_request_out;
   } pfm_func_t;

   typedef struct packed {
      pfm_port_arr_t   dir;
      pfm_port_arr_t   latch;
      logic [1:0][7:0] pulse_en;
      logic            host_en;
      logic [1:0]      mode;
      logic            mode_ok;
      logic [1:0]      mode_wait;
      logic [1:0]      mode_s1;
      logic [1:0]      mode_s2;
      pfm_port_arr_t   pin_s1;
      pfm_port_arr_t   pin_s2;
      pfm_port_arr_t   pin_out;
      pfm_port_arr_t   pin_oe;
      logic            ack;
      logic [31:0]     rdat;
      logic [2:0]      rs;
   } pfm_state_t;

endpackage

// [bench/pfm_ext_model.sv]
// far-side model: external bus devices or host processor on the port pins
// assumes level/oe pairs from the mux and a bench that sets what the far side drives
`timescale 1ns/1ps
module pfm_ext_model (
   input  wire pfm_pkg::pfm_port_arr_t pin_out,
   input  wire pfm_pkg::pfm_port_arr_t pin_oe,
   input  wire pfm_pkg::pfm_port_arr_t ext_drv,
   output pfm_pkg::pfm_port_arr_t      pin_in
);
   import pfm_pkg::*;

   // device drive wins where enabled; elsewhere the far side sets the level,
   // including the host register selects on port 8 pins 2..0
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule

// [bench/tb.sv]
// self-checking bench for the port pin-function mux
// assumes classic Wishbone access and the far-side model on the pins
`timescale 1ns/1ps
module tb;
   import pfm_pkg::*;
   logic          sys_clk = 1'b0;
   logic          srst = 1'b1;
   logic [1:0]    mode_pin = 2'h3;
   pfm_wb_req_t   wbr = '0;
   pfm_func_t     func = '{addr: 16'h5AC3, pulse: 16'h0F96, xbus_out: 8'h71, xbus_oe: 1'b1,
                           host_out: 8'hE4, host_oe: 1'b1, write_request_out: 1'b1, default: '0};
   pfm_port_arr_t ext_drv = '0;
   pfm_port_arr_t pin_in, pin_out, pin_oe, pin_level;
   logic [31:0]   wb_dat_o, rd;
   logic          wb_ack_o;
   logic [2:0]    host_reg_select;
   int            fails = 0;
   int            n_compared = 0;

   // 50 MHz
   always #10 sys_clk = ~sys_clk;

   pfm_port_mux u_dut (.sys_clk(sys_clk), .srst(srst), .wb_i(wbr), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .mode_pin(mode_pin), .func_i(func), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level), .host_reg_select(host_reg_select));
   pfm_ext_model u_ext (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv), .pin_in(pin_in));

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // mode is strapped during reset; the mux catches it a few edges after release
   task automatic do_reset(input logic [1:0] m);
      @(posedge sys_clk);
      srst <= 1'b1;
      mode_pin <= m;
      repeat (10) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask

   // one classic cycle: hold until ack is sampled, then release for at least a cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge sys_clk);
      wbr <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: {24'h0, d}};
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wbr <= '0;
      if (n >= 50) begin
         fails++;
         $display("[FAIL] wb ack expected 1 seen 0");
      end
   endtask

   // pins lag the register write by a cycle
   task automatic settle;
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   task automatic t_mode1;
      do_reset(PFM_MODE_EXP1);
      wb(1'b0, 8'h00, 8'h00);
      chk("p1 dir", 8'hFF, rd[7:0]);
      settle;
      chk("p1 oe", 8'hFF, pin_oe[PFM_P1]);
      chk("p2 out", 8'h5A, pin_out[PFM_P2]);
      chk("p3 out", 8'h71, pin_out[PFM_P3]);
      $display("test mode1 done");
   endtask

   task automatic t_mode2;
      do_reset(PFM_MODE_EXP2);
      settle;
      chk("p1 oe idle", 8'h00, pin_oe[PFM_P1]);
      wb(1'b1, 8'h00, 8'hFF);
      settle;
      chk("p1 addr", 8'hC3, pin_out[PFM_P1]);
      chk("p3 oe", 8'hFF, pin_oe[PFM_P3]);
      $display("test mode2 done");
   endtask

   task automatic t_mode3;
      do_reset(PFM_MODE_SINGLE);
      wb(1'b0, 8'h00, 8'h00);
      chk("p1 dir", 8'h00, rd[7:0]);
      wb(1'b1, 8'h20, 8'hA5);
      wb(1'b1, 8'h00, 8'hFF);
      settle;
      chk("p1 latch out", 8'hA5, pin_out[PFM_P1]);
      chk("p3 idle oe", 8'h00, pin_oe[PFM_P3]);
      wb(1'b0, 8'h20, 8'h00);
      chk("p1 read", 8'hA5, rd[7:0]);
      wb(1'b1, 8'h40, 8'hFF);
      ext_drv[PFM_P4] <= 8'h3C;
      ext_drv[PFM_P7] <= 8'hB4;
      settle;
      chk("p1 pulse", 8'h96, pin_out[PFM_P1]);
      wb(1'b0, 8'h2C, 8'h00);
      chk("p4 pins", 8'h3C, rd[7:0]);
      chk("p4 level", 8'h3C, pin_level[PFM_P4]);
      wb(1'b0, 8'h38, 8'h00);
      chk("p7 read", 8'hB4, rd[7:0]);
      chk("p7 level", 8'hB4, pin_level[PFM_P7]);
      wb(1'b1, 8'h18, 8'hFF);
      wb(1'b0, 8'h18, 8'h00);
      chk("p7 dir", 8'h00, rd[7:0]);
      chk("p7 oe", 8'h00, pin_oe[PFM_P7]);
      wb(1'b0, 8'hFC, 8'h00);
      chk("unmapped", 8'h00, rd[7:0]);
      // on-chip functions ask for pins; host port still off
      func.p4_oe   <= 8'h0F;
      func.p4_out  <= 8'h09;
      func.s0_oe   <= 3'h5;
      func.s0_out  <= 3'h1;
      func.frt_oe  <= 8'h03;
      func.frt_out <= 8'h02;
      func.t8_oe   <= 8'h30;
      func.t8_out  <= 8'h30;
      func.s1_oe   <= 8'h11;
      func.s1_out  <= 8'h10;
      func.alt_out <= 8'hC6;
      func.alt_oe  <= 1'b1;
      settle;
      chk("p4 timer oe", 8'h0F, pin_oe[PFM_P4]);
      chk("p4 timer out", 8'h09, pin_out[PFM_P4]);
      chk("p5 serial oe", 8'h05, pin_oe[PFM_P5]);
      chk("p5 serial out", 8'h01, pin_out[PFM_P5]);
      chk("p6 frt oe", 8'h03, pin_oe[PFM_P6]);
      chk("p6 frt out", 8'h02, pin_out[PFM_P6]);
      chk("p8 gpio oe", 8'h11, pin_oe[PFM_P8]);
      chk("p8 gpio out", 8'h10, pin_out[PFM_P8]);
      $display("test mode3 done");
   endtask

   task automatic t_host;
      wb(1'b1, 8'h48, 8'h01);
      ext_drv[PFM_P8] <= 8'h05;
      settle;
      chk("p3 host", 8'hE4, pin_out[PFM_P3]);
      chk("p3 oe", 8'hFF, pin_oe[PFM_P3]);
      chk("reg sel", 8'h05, {5'h0, host_reg_select});
      chk("p8 wrq", 8'h08, pin_out[PFM_P8] & pin_oe[PFM_P8] & PFM_P8_WRQ);
      chk("p8 in", 8'h00, pin_oe[PFM_P8] & PFM_P8_HOSTIN);
      chk("p4 alt out", 8'hC6, pin_out[PFM_P4]);
      chk("p4 alt oe", 8'hFF, pin_oe[PFM_P4]);
      chk("p6 t8 oe", 8'h33, pin_oe[PFM_P6]);
      chk("p6 t8 out", 8'h32, pin_out[PFM_P6]);
      wb(1'b1, 8'h48, 8'h00);
      settle;
      chk("reg sel off", 8'h00, {5'h0, host_reg_select});
      chk("p4 back", 8'h0F, pin_oe[PFM_P4]);
      chk("p6 back", 8'h03, pin_oe[PFM_P6]);
      chk("p3 back", 8'h00, pin_oe[PFM_P3]);
      $display("test host done");
   endtask

   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      t_mode1;
      t_mode2;
      t_mode3;
      t_host;
      tally_and_finish;
   end

   // the tests need well under 2,000 cycles
   initial begin
      #400000;
      fails++;
      tally_and_finish;
   end
endmodule
